// ===== src/crtra_pkg.sv
// Constants, types and register map for the refresh memory access block.
// Assumes a single 10 MHz clock and an AHB-Lite master in front of it.
package crtra_pkg;

    // ========================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CRTRA_OFF_STATUS  = 8'h00; // Status
    localparam logic [7:0] CRTRA_OFF_MODE    = 8'h20; // Mode control
    localparam logic [7:0] CRTRA_OFF_UPD_HI  = 8'h48; // Update addr high
    localparam logic [7:0] CRTRA_OFF_UPD_LO  = 8'h4c; // Update addr low
    localparam logic [7:0] CRTRA_OFF_DUMMY   = 8'h7c; // Dummy location

    // ========================================================
    // Field positions
    localparam int CRTRA_MODE_TRANSP_BIT  = 3; // Transparent addressing
    localparam int CRTRA_MODE_DE_SKEW_BIT = 4; // Display enable delay
    localparam int CRTRA_MODE_CUR_SKEW_BIT = 5; // Cursor delay
    localparam int CRTRA_MODE_BLANK_BIT   = 6; // Blanking-only updates
    localparam int CRTRA_STAT_VRET_BIT    = 5; // Vertical retrace
    localparam int CRTRA_STAT_READY_BIT   = 7; // Update ready

    // ========================================================
    // Reset values
    localparam logic [7:0]  CRTRA_MODE_RST = 8'h00;
    localparam logic [13:0] CRTRA_UPD_RST  = 14'h0000;
    localparam logic [13:0] CRTRA_REF_RST  = 14'h0000;

    // ========================================================
    // Timing: character clock period, rounded up to whole cycles
    localparam int CRTRA_CLK_PERIOD_NS  = 100;
    localparam int CRTRA_CHCLK_PERIOD_NS = 400;
    localparam int CRTRA_CHCLK_CYCLES    =
        (CRTRA_CHCLK_PERIOD_NS + CRTRA_CLK_PERIOD_NS - 1)
        / CRTRA_CLK_PERIOD_NS;
    localparam logic [1:0] CRTRA_CHCLK_LAST =
        2'(CRTRA_CHCLK_CYCLES - 1);

    // ========================================================
    // Types
    typedef struct packed {
        logic        hsel;    // Slave select
        logic [31:0] haddr;   // Byte address
        logic [1:0]  htrans;  // Transfer type
        logic        hwrite;  // Write when high
        logic [2:0]  hsize;   // Transfer size
        logic [31:0] hwdata;  // Write data (data phase)
        logic        hready;  // Bus ready
    } crtra_ahb_req_type;

    typedef struct packed {
        logic hblank;         // Horizontal blanking
        logic vblank;         // Vertical blanking
        logic display_enable; // Raw display enable
        logic cursor;         // Raw cursor
        logic frame_start;    // Reload refresh counter
        logic phase2;         // Second bus phase
    } crtra_video_type;

    typedef enum logic [2:0] {
        CRTRA_UPD_IDLE   = 3'b001,  // No update pending
        CRTRA_UPD_WAIT   = 3'b010,  // Waiting for blanking
        CRTRA_UPD_STROBE = 3'b100   // Update address on the lines
    } crtra_upd_state_type;

endpackage

// ===== src/crtra_top.sv
// Refresh memory address arbitration, update strobe and skew logic.
// Assumes video timing inputs synchronous to mclk_i and a single
// AHB-Lite master that issues whole-word single transfers.
`timescale 1ns/10ps
`default_nettype none

module crtra_top (
    // Clock and reset
    input  wire  logic                       mclk_i,
    input  wire  logic                       rst_b_i,
    // AHB-Lite slave
    input  wire  crtra_pkg::crtra_ahb_req_type ahb_i,
    output logic [31:0]                      hrdata_o,
    output logic                             hreadyout_o,
    output logic                             hresp_o,
    // Video timing
    input  wire  crtra_pkg::crtra_video_type video_i,
    // Memory side
    output logic [13:0]                      refresh_address_lines_o,
    output logic                             update_strobe_o,
    output logic                             display_enable_o,
    output logic                             cursor_o,
    output logic                             character_clock_o
);
    import crtra_pkg::*;

    // ========================================================
    // Address decode helper
    function automatic logic hit(input logic [31:0] a,
                                 input logic [7:0] off);
        hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
    endfunction

    // ========================================================
    // Declarations
    logic [1:0]  chclk_cnt_r;      // Character clock divider
    logic [1:0]  chclk_cnt_nxt;
    logic        chclk_tick;       // One-cycle character enable
    logic [13:0] ref_cnt_r;        // Refresh character counter
    logic [13:0] ref_cnt_nxt;
    logic [7:0]  mode_r;           // Mode control register
    logic [13:0] upd_addr_r;       // Update address register
    logic [13:0] upd_addr_nxt;
    logic        ready_r;          // Update ready flag
    logic        ready_nxt;
    crtra_upd_state_type state_r;  // Blanking update sequencer
    crtra_upd_state_type state_nxt;
    logic [13:0] lines_r;          // Registered address lines
    logic [13:0] lines_nxt;
    logic        strobe_r;         // Registered update strobe
    logic        strobe_nxt;
    logic [1:0]  skew_d_r;         // One-character delayed copies
    logic [1:0]  skew_o_r;         // Output flops, DE and cursor
    logic [1:0]  skew_raw;         // Raw DE and cursor
    logic [1:0]  skew_sel;         // Delay selects from mode bits
    logic        wr_pend_r;        // Write data phase pending
    logic [7:0]  wr_off_r;         // Offset of pending write
    logic [31:0] hrdata_r;         // Read data flop
    logic [31:0] rd_val;           // Read mux
    logic [31:0] stat_word;        // Status register image
    logic        acc;              // Address phase accepted
    logic        dummy_acc;        // Dummy location touched
    logic        transp;           // Transparent addressing
    logic        blank_mode;       // Blanking-only variant
    logic        blanking;         // Any blanking interval
    logic        wr_hi;            // Software writes high byte
    logic        wr_lo;            // Software writes low byte
    logic        upd_done;         // Blanking update finished
    logic        inc_now;          // Interleaved update increment

    // ========================================================
    // Bus decode (single cycle, always ready, always OKAY)
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign hrdata_o    = hrdata_r;
    assign acc       = ahb_i.hsel & ahb_i.htrans[1] & ahb_i.hready;
    // A read or a write of the dummy location both count as an update
    assign dummy_acc = acc & hit(ahb_i.haddr, CRTRA_OFF_DUMMY);
    assign wr_hi     = wr_pend_r & (wr_off_r == CRTRA_OFF_UPD_HI);
    assign wr_lo     = wr_pend_r & (wr_off_r == CRTRA_OFF_UPD_LO);

    // Read mux; unmapped offsets and the dummy location read zero
    assign stat_word =
        (32'(ready_r) << CRTRA_STAT_READY_BIT) |
        (32'(video_i.vblank) << CRTRA_STAT_VRET_BIT);
    assign rd_val =
        hit(ahb_i.haddr, CRTRA_OFF_STATUS) ? stat_word :
        hit(ahb_i.haddr, CRTRA_OFF_MODE)   ? {24'h000000, mode_r} :
        hit(ahb_i.haddr, CRTRA_OFF_UPD_HI) ?
            {26'h0000000, upd_addr_r[13:8]} :
        hit(ahb_i.haddr, CRTRA_OFF_UPD_LO) ?
            {24'h000000, upd_addr_r[7:0]} : 32'h00000000;

    // ========================================================
    // Mode decode
    assign transp     = mode_r[CRTRA_MODE_TRANSP_BIT];
    assign blank_mode = mode_r[CRTRA_MODE_BLANK_BIT];
    assign blanking   = video_i.hblank | video_i.vblank;

    // ========================================================
    // Character clock enable from the divider
    assign chclk_tick    = (chclk_cnt_r == CRTRA_CHCLK_LAST);
    assign chclk_cnt_nxt = chclk_tick ? 2'h0 : chclk_cnt_r + 2'h1;
    assign character_clock_o = chclk_tick;

    // Refresh counter runs through blanking too, for dynamic memory
    assign ref_cnt_nxt = video_i.frame_start ? CRTRA_REF_RST :
                         chclk_tick ? ref_cnt_r + 14'h0001 : ref_cnt_r;

    // Divider and refresh counter
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            chclk_cnt_r <= 2'h0;
            ref_cnt_r   <= CRTRA_REF_RST;
        end else begin
            chclk_cnt_r <= chclk_cnt_nxt;
            ref_cnt_r   <= ref_cnt_nxt;
        end
    end

    // ========================================================
    // Blanking update sequencer
    // A dummy access in transparent blanking mode arms it; the update address goes out for one
    // whole character period once blanking is seen on a tick.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            CRTRA_UPD_IDLE: begin
                if (dummy_acc && transp && blank_mode) begin
                    state_nxt = CRTRA_UPD_WAIT;
                end
            end
            CRTRA_UPD_WAIT: begin
                // Never outside blanking, so the picture stays clean
                if (chclk_tick && blanking) begin
                    state_nxt = CRTRA_UPD_STROBE;
                end
            end
            CRTRA_UPD_STROBE: begin
                if (chclk_tick) begin
                    state_nxt = CRTRA_UPD_IDLE;
                end
            end
            default: begin
                state_nxt = CRTRA_UPD_IDLE;
            end
        endcase
    end

    assign upd_done = (state_r == CRTRA_UPD_STROBE) & chclk_tick;
    // Interleaved mode: update happens every phase two, so count now
    assign inc_now  = dummy_acc & transp & ~blank_mode;

    // ========================================================
    // Update address and ready flag
    // High byte of the update address keeps only its six live bits
    function automatic logic [5:0] wr_off_hi_data(input logic [31:0] d);
        wr_off_hi_data = d[5:0];
    endfunction

    // Software writes win over the increment: a reload is deliberate.
    always_comb begin
        upd_addr_nxt = upd_addr_r;
        if (upd_done || inc_now) begin
            upd_addr_nxt = upd_addr_r + 14'h0001;
        end
        if (wr_hi) begin
            upd_addr_nxt[13:8] = wr_off_hi_data(ahb_i.hwdata);
        end
        if (wr_lo) begin
            upd_addr_nxt[7:0] = ahb_i.hwdata[7:0];
        end
    end

    // Ready falls when an update is armed; completion sets it, and a
    // completion in the same cycle as a clear wins.
    assign ready_nxt = (upd_done | inc_now) ? 1'b1 :
                       (dummy_acc & transp & blank_mode) ? 1'b0 :
                       ready_r;

    // ========================================================
    // Address line selection
    // Shared: counter only. Transparent: update address in phase two (interleaved only) or during the strobe, else counter.
    assign strobe_nxt = transp & blank_mode &
                        (state_r == CRTRA_UPD_STROBE);
    always_comb begin
        lines_nxt = ref_cnt_r;
        if (transp) begin
            if (!blank_mode && video_i.phase2) begin
                lines_nxt = upd_addr_r;
            end else if (strobe_nxt) begin
                lines_nxt = upd_addr_r;
            end
        end
    end

    // ========================================================
    // Skew: display enable and cursor each delayed one character when its mode bit is set
    assign skew_raw = {video_i.cursor, video_i.display_enable};
    assign skew_sel = {mode_r[CRTRA_MODE_CUR_SKEW_BIT],
                       mode_r[CRTRA_MODE_DE_SKEW_BIT]};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_skew
            always_ff @(posedge mclk_i) begin
                if (!rst_b_i) begin
                    skew_d_r[g] <= 1'b0;
                    skew_o_r[g] <= 1'b0;
                end else begin
                    if (chclk_tick) begin
                        skew_d_r[g] <= skew_raw[g];
                    end
                    // Delayed copy keeps slow memories in step
                    skew_o_r[g] <= skew_sel[g] ? skew_d_r[g] :
                                   skew_raw[g];
                end
            end
        end
    endgenerate
    assign display_enable_o = skew_o_r[0];
    assign cursor_o         = skew_o_r[1];

    // ========================================================
    // Register state
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            mode_r     <= CRTRA_MODE_RST;
            upd_addr_r <= CRTRA_UPD_RST;
            ready_r    <= 1'b0;
            state_r    <= CRTRA_UPD_IDLE;
            lines_r    <= CRTRA_REF_RST;
            strobe_r   <= 1'b0;
            wr_pend_r  <= 1'b0;
            wr_off_r   <= 8'h00;
            hrdata_r   <= 32'h00000000;
        end else begin
            state_r    <= state_nxt;
            upd_addr_r <= upd_addr_nxt;
            ready_r    <= ready_nxt;
            lines_r    <= lines_nxt;
            strobe_r   <= strobe_nxt;
            wr_pend_r  <= acc & ahb_i.hwrite;
            wr_off_r   <= (ahb_i.haddr[31:8] == 24'h000000) ?
                          ahb_i.haddr[7:0] : 8'hff;
            // Read data is caught at the address phase edge
            if (acc && !ahb_i.hwrite) begin
                hrdata_r <= rd_val;
            end
            if (wr_pend_r && wr_off_r == CRTRA_OFF_MODE) begin
                mode_r <= ahb_i.hwdata[7:0];
            end
        end
    end
    assign refresh_address_lines_o = lines_r;
    assign update_strobe_o         = strobe_r;

    // ========================================================
    // Assertions
    sequence s_strobe_run;
        update_strobe_o [*4] ##1 !update_strobe_o;
    endsequence

    a_vretrace_status: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        (acc && !ahb_i.hwrite && hit(ahb_i.haddr, CRTRA_OFF_STATUS))
        |=> hrdata_o[CRTRA_STAT_VRET_BIT] == $past(video_i.vblank))
        else $error("status bit 5 does not follow vertical blanking");

    a_shared_addr_lines: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        !transp |=> refresh_address_lines_o == $past(ref_cnt_r))
        else $error("shared mode address lines not refresh counter");

    a_interleave_addr: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        (transp && !blank_mode && video_i.phase2)
        |=> refresh_address_lines_o == $past(upd_addr_r))
        else $error("update address missing in phase two");

    a_blank_only_upd: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        $rose(update_strobe_o) |-> $past(blanking))
        else $error("update started outside blanking");

    a_strobe_with_addr: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        update_strobe_o |-> refresh_address_lines_o == $past(upd_addr_r))
        else $error("strobe without update address on the lines");

    a_strobe_length: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        ($rose(update_strobe_o) && transp && blank_mode)
        |-> s_strobe_run)
        else $error("strobe not one character period long");

    a_upd_increment: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        (upd_done && !wr_hi && !wr_lo)
        |=> upd_addr_r == $past(upd_addr_r) + 14'h0001 && ready_r)
        else $error("update address not advanced after update");

    a_dummy_ready: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        (inc_now && !wr_hi && !wr_lo)
        |=> ready_r && upd_addr_r == $past(upd_addr_r) + 14'h0001)
        else $error("dummy access did not count or set ready");

    a_cursor_skew: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        (chclk_tick && skew_sel[1]) ##1 skew_sel[1]
        |=> cursor_o == $past(video_i.cursor, 2))
        else $error("cursor not delayed one character");

    a_de_no_skew: assert property (@(posedge mclk_i)
        disable iff (!rst_b_i)
        !skew_sel[0] |=> display_enable_o == $past(video_i.display_enable))
        else $error("display enable delayed without skew bit");

endmodule

`default_nettype wire

// ===== tb/crtra_mem_model.sv
// Far-side model: refresh memory, its address mux and the data hold latch.
// Assumes the bench drives the CPU side and the block drives the lines.
`timescale 1ns/10ps
`default_nettype none

module crtra_mem_model (
    // Clock
    input  wire logic        mclk_i,
    // Block side
    input  wire logic [13:0] refresh_address_lines_i,
    input  wire logic        update_strobe_i,
    input  wire logic        phase2_i,
    // CPU side
    input  wire logic        cpu_req_i,
    input  wire logic [13:0] cpu_addr_i,
    input  wire logic [7:0]  char_i,
    input  wire logic        char_load_i,
    // Inspection port
    input  wire logic [13:0] peek_addr_i,
    output logic      [13:0] mem_addr_o,
    output logic      [7:0]  peek_data_o
);
    // ========================================================
    // Storage
    logic [7:0] mem [0:16383];  // Display memory
    logic [7:0] hold_r;         // Character held until retrace

    // CPU wins at once on request or in phase two, else refresh lines
    assign mem_addr_o = (cpu_req_i | phase2_i) ? cpu_addr_i
                                               : refresh_address_lines_i;
    assign peek_data_o = mem[peek_addr_i];

    // Latch keeps the CPU character so the CPU never waits for blanking
    always_ff @(posedge mclk_i) begin
        if (char_load_i) begin
            hold_r <= char_i;
        end
        if (update_strobe_i) begin
            mem[refresh_address_lines_i] <= hold_r;
        end
    end
endmodule

`default_nettype wire

// ===== tb/test_crtc_refresh_memory_access.sv
// Self-checking bench for the refresh memory access block.
// Assumes a 10 MHz clock and an always-ready single AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none

module test_crtc_refresh_memory_access;
    import crtra_pkg::*;
    // ========================================================
    // Signals
    logic              mclk_i = 1'b0;       // Bench clock
    logic              rst_b_i = 1'b0;      // Reset, active low
    crtra_ahb_req_type ahb_m;               // Master-driven fields
    crtra_ahb_req_type ahb_w;               // With hready looped back
    crtra_video_type   vid;                 // Video timing inputs
    logic [31:0]       hrdata_o;
    logic              hreadyout_o, hresp_o, update_strobe_o;
    logic              display_enable_o, cursor_o, character_clock_o;
    logic [13:0]       lines, mem_addr, cpu_addr;
    logic              cpu_req, char_load;
    logic [7:0]        char_d, peek_d;
    logic [31:0]       rd;
    int                n_fail = 0, num_checks = 0, cyc = 0, n;
    // Ordinary register cases: address, write data, expected read
    logic [7:0]        t_a [5] = '{8'h20, 8'h10, 8'h4c, 8'h48, 8'h20};
    logic [31:0]       t_w [5] = '{32'ha5, 32'hff, 32'h34, 32'h12, 32'h00};
    logic [31:0]       t_e [5] = '{32'ha5, 32'h00, 32'h34, 32'h12, 32'h00};

    always #50 mclk_i = ~mclk_i;
    always_comb begin
        ahb_w        = ahb_m;
        ahb_w.hready = hreadyout_o;
    end

    crtra_top DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ahb_i(ahb_w),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .video_i(vid), .refresh_address_lines_o(lines),
        .update_strobe_o(update_strobe_o),
        .display_enable_o(display_enable_o), .cursor_o(cursor_o),
        .character_clock_o(character_clock_o));

    crtra_mem_model mem_far (.mclk_i(mclk_i), .refresh_address_lines_i(lines),
        .update_strobe_i(update_strobe_o), .phase2_i(vid.phase2),
        .cpu_req_i(cpu_req), .cpu_addr_i(cpu_addr), .char_i(char_d),
        .char_load_i(char_load), .peek_addr_i(14'h1235),
        .mem_addr_o(mem_addr), .peek_data_o(peek_d));

    // ========================================================
    // Helpers
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One whole-word single transfer; waits on hready with no bound of its own
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] r);
        @(posedge mclk_i);
        ahb_m.hsel   <= 1'b1;
        ahb_m.haddr  <= {24'h000000, a};
        ahb_m.htrans <= 2'b10;
        ahb_m.hwrite <= w;
        // Only the hang guard ends a wait for ready
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        ahb_m.hsel   <= 1'b0;
        ahb_m.htrans <= 2'b00;
        ahb_m.hwdata <= wd;
        do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask

    // Counts clocks from a raw input change until the output follows
    task automatic lag(input logic cur, output int d);
        d = 0;
        do begin
            @(posedge mclk_i);
            #1;
            d++;
        end while ((cur ? cursor_o : display_enable_o) !== 1'b1 && d < 20);
    endtask

    task automatic wrap_up;
        $display("TB: %0d checks, %0d mismatches", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: the tests need well under a thousand clocks
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    // ========================================================
    // Main sequence
    initial begin
        ahb_m = '0;
        ahb_m.hsize = 3'b010;
        vid = '0;
        {cpu_req, char_load, char_d, cpu_addr} = '0;
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        #1;
        check("lines", 32'(lines), 32'h0);
        check("strobe", 32'(update_strobe_o), 32'h0);
        check("ready", 32'({hreadyout_o, hresp_o}), 32'h2);
        $display("TB: reset test done");
        // Register table: write then read back each row
        for (int i = 0; i < 5; i++) begin
            bus(t_a[i], 1'b1, t_w[i], rd);
            bus(t_a[i], 1'b0, 32'h0, rd);
            check("reg", rd & 32'hff, t_e[i]);
        end
        $display("TB: register table done");
        // Retrace flag follows vertical blanking, polled by the CPU
        for (int v = 1; v >= 0; v--) begin
            vid.vblank <= v[0];
            bus(CRTRA_OFF_STATUS, 1'b0, 32'h0, rd);
            check("vret", 32'(rd[5]), 32'(v));
        end
        $display("TB: retrace flag done");
        // Shared mode: lines show the counter, reloaded by frame start
        vid.frame_start <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        check("shared", 32'(lines), 32'h0);
        // Free-running counter: one step per character period
        vid.frame_start <= 1'b0;
        cpu_req <= 1'b1;
        cpu_addr <= 14'h0abc;
        @(posedge mclk_i);
        #1;
        rd = 32'(lines);
        repeat (CRTRA_CHCLK_CYCLES) @(posedge mclk_i);
        #1;
        check("count", 32'(lines), rd + 32'h1);
        check("prio", 32'(mem_addr), 32'h0abc);
        cpu_req <= 1'b0;
        vid.frame_start <= 1'b1;
        $display("TB: shared mode done");
        // Skew: none, then both delays on
        for (int s = 0; s < 2; s++) begin
            bus(CRTRA_OFF_MODE, 1'b1, s ? 32'h30 : 32'h00, rd);
            for (int c = 0; c < 2; c++) begin
                // Change the input just after a character boundary
                do begin
                    @(posedge mclk_i);
                    #1;
                end while (character_clock_o !== 1'b1);
                @(posedge mclk_i);
                if (c) vid.cursor <= 1'b1;
                else vid.display_enable <= 1'b1;
                lag(c[0], n);
                check("skew", 32'(n),
                      s ? 32'(CRTRA_CHCLK_CYCLES + 1) : 32'h1);
                vid.cursor <= 1'b0;
                vid.display_enable <= 1'b0;
                repeat (8) @(posedge mclk_i);
            end
        end
        $display("TB: skew done");
        // Transparent interleave: update address in phase two only
        bus(CRTRA_OFF_MODE, 1'b1, 32'h08, rd);
        bus(CRTRA_OFF_UPD_HI, 1'b1, 32'h12, rd);
        bus(CRTRA_OFF_UPD_LO, 1'b1, 32'h34, rd);
        #1;
        check("ph1", 32'(lines), 32'h0);
        check("mux1", 32'(mem_addr), 32'h0);
        cpu_addr <= 14'h0abc;
        vid.phase2 <= 1'b1;
        @(posedge mclk_i);
        #1;
        check("ph2", 32'(lines), 32'h1234);
        check("mux", 32'(mem_addr), 32'h0abc);
        bus(CRTRA_OFF_DUMMY, 1'b1, 32'h0, rd);
        bus(CRTRA_OFF_STATUS, 1'b0, 32'h0, rd);
        check("rdy", 32'(rd[7]), 32'h1);
        check("inc", 32'(lines), 32'h1235);
        vid.phase2 <= 1'b0;
        $display("TB: interleave done");
        // Transparent blanking: strobe waits for blanking, lasts 4 clocks
        bus(CRTRA_OFF_MODE, 1'b1, 32'h48, rd);
        char_d <= 8'h5a;
        char_load <= 1'b1;
        bus(CRTRA_OFF_DUMMY, 1'b1, 32'h0, rd);
        char_load <= 1'b0;
        bus(CRTRA_OFF_STATUS, 1'b0, 32'h0, rd);
        check("armed", 32'({rd[7], update_strobe_o}), 32'h0);
        vid.hblank <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (update_strobe_o !== 1'b1 && n < 20);
        check("strobe_addr", 32'(lines), 32'h1235);
        n = 0;
        while (update_strobe_o === 1'b1 && n < 10) begin
            n++;
            @(posedge mclk_i);
            #1;
        end
        check("strobe_len", 32'(n), 32'(CRTRA_CHCLK_CYCLES));
        vid.hblank <= 1'b0;
        check("latched", 32'(peek_d), 32'h5a);
        bus(CRTRA_OFF_STATUS, 1'b0, 32'h0, rd);
        check("rdy2", 32'(rd[7]), 32'h1);
        $display("TB: blanking update done");
        // Second reset in mid-run clears mode and ready
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        bus(CRTRA_OFF_STATUS, 1'b0, 32'h0, rd);
        check("rst_rdy", 32'(rd[7]), 32'h0);
        bus(CRTRA_OFF_MODE, 1'b0, 32'h0, rd);
        check("rst_mode", rd & 32'hff, 32'h0);
        $display("TB: second reset done");
        wrap_up();
    end
endmodule

`default_nettype wire
